// File: rtl/cpu_clock_mode_selector.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_mode_selector #(
    parameter int PLL_HALF = clk_sel_pkg::PLL_FREE_HALF_CYC,
    parameter int OWD_OVERFLOW = clk_sel_pkg::OWD_OVERFLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Straps and input clock
    input wire logic [2:0] clock_select_pins,
    input wire logic crystal_input_pin,
    // Software control
    input wire logic osc_watchdog_disable,
    // CPU clock and status
    output logic cpu_clk_ff,
    output logic cpu_edge_ff,
    output clk_sel_pkg::clk_cfg_t cfg_ff,
    output logic owd_irq_ff,
    output logic clk_fail_ff
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture; no async reset so the pins can be sampled in reset
    logic [2:0] sel_ff;
    logic [2:0] nxt_sel;

    always_comb
    begin
        nxt_sel = sel_ff;
        if (!rst_sync_ff)
        begin
            nxt_sel = clock_select_pins;
        end
    end

    always_ff @(posedge clk)
    begin
        sel_ff <= nxt_sel;
    end

    ////////////////////////////////////////////////////////////////////////
    clk_sel_pkg::clk_src_t src_ff;
    clk_sel_pkg::clk_src_t nxt_src;
    clk_sel_pkg::clk_cfg_t nxt_cfg;
    logic owd_overflow;
    logic nxt_fail;
    logic nxt_irq;

    always_comb
    begin
        nxt_fail = clk_fail_ff || owd_overflow;
        nxt_irq = owd_overflow && !clk_fail_ff;
        if (nxt_fail)
        begin
            nxt_src = clk_sel_pkg::SRC_FAILSAFE;
        end
        else
        begin
            case (sel_ff)
                clk_sel_pkg::SEL_DIRECT: nxt_src = clk_sel_pkg::SRC_DIRECT;
                clk_sel_pkg::SEL_PRESC: nxt_src = clk_sel_pkg::SRC_PRESC;
                default: nxt_src = clk_sel_pkg::SRC_PLL;
            endcase
        end
        nxt_cfg.osc_amp_enable = (nxt_src != clk_sel_pkg::SRC_DIRECT);
        nxt_cfg.ext_clk_accept = (nxt_src == clk_sel_pkg::SRC_DIRECT);
        // Free-running PLL feeds the watchdog in non-PLL modes
        nxt_cfg.pll_enable = (nxt_src == clk_sel_pkg::SRC_PLL)
            || (nxt_src == clk_sel_pkg::SRC_FAILSAFE) || !osc_watchdog_disable;
        case (sel_ff)
            clk_sel_pkg::SEL_X4: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X4;
            clk_sel_pkg::SEL_X3: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X3;
            clk_sel_pkg::SEL_X8: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X8;
            clk_sel_pkg::SEL_X5: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X5;
            clk_sel_pkg::SEL_X10: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X10;
            clk_sel_pkg::SEL_X16: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X16;
            clk_sel_pkg::SEL_PRESC: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_DIV2;
            default: nxt_cfg.pll_factor = clk_sel_pkg::FACTOR_X1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running PLL stand-in: fixed half period, not locked to input
    logic [7:0] pll_div_ff;
    logic [7:0] nxt_pll_div;
    logic pll_clk_ff;
    logic nxt_pll_clk;
    logic pll_tick;
    logic xtal_q_ff;
    logic xtal_edge;
    logic xtal_rise;
    logic nxt_cpu_clk;

    assign xtal_edge = crystal_input_pin ^ xtal_q_ff;
    assign xtal_rise = crystal_input_pin && !xtal_q_ff;
    assign pll_tick = cfg_ff.pll_enable && !pll_clk_ff && (pll_div_ff == 8'(PLL_HALF - 1));

    always_comb
    begin
        nxt_pll_div = 8'h00;
        nxt_pll_clk = 1'b0;
        if (cfg_ff.pll_enable)
        begin
            nxt_pll_clk = pll_clk_ff;
            nxt_pll_div = pll_div_ff + 8'h01;
            if (pll_div_ff == 8'(PLL_HALF - 1))
            begin
                nxt_pll_div = 8'h00;
                nxt_pll_clk = !pll_clk_ff;
            end
        end
        case (src_ff)
            clk_sel_pkg::SRC_DIRECT: nxt_cpu_clk = crystal_input_pin;
            clk_sel_pkg::SRC_PRESC: nxt_cpu_clk = cpu_clk_ff ^ xtal_rise;
            clk_sel_pkg::SRC_PLL: nxt_cpu_clk = pll_clk_ff;
            clk_sel_pkg::SRC_FAILSAFE: nxt_cpu_clk = pll_clk_ff;
            default: nxt_cpu_clk = 1'b0;
        endcase
    end

    osc_watchdog #(
        .OVERFLOW(OWD_OVERFLOW)
    ) u_owd (
        .clk(clk),
        .rst_n(rst_sync_ff),
        .enable(!osc_watchdog_disable && ((src_ff == clk_sel_pkg::SRC_PRESC)
            || (src_ff == clk_sel_pkg::SRC_DIRECT))),
        .pll_tick(pll_tick),
        .xtal_edge(xtal_edge),
        .overflow_ff(owd_overflow)
    );

    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            src_ff <= clk_sel_pkg::SRC_PLL;
            cfg_ff <= '0;
            pll_div_ff <= 8'h00;
            pll_clk_ff <= 1'b0;
            xtal_q_ff <= 1'b0;
            cpu_clk_ff <= 1'b0;
            cpu_edge_ff <= 1'b0;
            owd_irq_ff <= 1'b0;
            clk_fail_ff <= 1'b0;
        end
        else
        begin
            src_ff <= nxt_src;
            cfg_ff <= nxt_cfg;
            pll_div_ff <= nxt_pll_div;
            pll_clk_ff <= nxt_pll_clk;
            xtal_q_ff <= crystal_input_pin;
            cpu_clk_ff <= nxt_cpu_clk;
            cpu_edge_ff <= nxt_cpu_clk ^ cpu_clk_ff;
            owd_irq_ff <= nxt_irq;
            clk_fail_ff <= nxt_fail;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_strap;
        @(posedge clk) $rose(rst_sync_ff) |-> sel_ff == $past(clock_select_pins);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured");

    property p_hold;
        @(posedge clk) disable iff (!rst_sync_ff) 1'b1 |=> $stable(sel_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed after reset");

    property p_x16;
        @(posedge clk) disable iff (!rst_sync_ff)
        (sel_ff == clk_sel_pkg::SEL_X16) |=> cfg_ff.pll_factor == clk_sel_pkg::FACTOR_X16;
    endproperty
    a_x16: assert property (p_x16) else $error("wrong factor for code 000");

    property p_direct;
        @(posedge clk) disable iff (!rst_sync_ff)
        (src_ff == clk_sel_pkg::SRC_DIRECT) |=> cpu_clk_ff == $past(crystal_input_pin);
    endproperty
    a_direct: assert property (p_direct) else $error("direct clock not following input");

    sequence s_presc_rise;
        (src_ff == clk_sel_pkg::SRC_PRESC) && (nxt_src == clk_sel_pkg::SRC_PRESC) && xtal_rise;
    endsequence
    property p_presc;
        @(posedge clk) disable iff (!rst_sync_ff)
        s_presc_rise |=> cpu_clk_ff != $past(cpu_clk_ff) ##0 cpu_edge_ff;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler missed input edge");

    property p_presc_hold;
        @(posedge clk) disable iff (!rst_sync_ff)
        ((src_ff == clk_sel_pkg::SRC_PRESC) && (nxt_src == clk_sel_pkg::SRC_PRESC) && !xtal_rise)
            |=> $stable(cpu_clk_ff);
    endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("prescaler phase cut");

    property p_pll_off;
        @(posedge clk) disable iff (!rst_sync_ff)
        (osc_watchdog_disable && !clk_fail_ff && !owd_overflow
            && (sel_ff == clk_sel_pkg::SEL_PRESC || sel_ff == clk_sel_pkg::SEL_DIRECT))
            |=> !cfg_ff.pll_enable;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("PLL not switched off");

    property p_amp;
        @(posedge clk) disable iff (!rst_sync_ff)
        $past(rst_sync_ff) |-> cfg_ff.osc_amp_enable
            == ((sel_ff != clk_sel_pkg::SEL_DIRECT) || clk_fail_ff);
    endproperty
    a_amp: assert property (p_amp) else $error("amplifier state wrong");

    sequence s_fail_entry;
        owd_overflow && !clk_fail_ff;
    endsequence
    property p_fail;
        @(posedge clk) disable iff (!rst_sync_ff)
        s_fail_entry |=> owd_irq_ff && clk_fail_ff && (src_ff == clk_sel_pkg::SRC_FAILSAFE)
            ##1 !owd_irq_ff && clk_fail_ff;
    endproperty
    a_fail: assert property (p_fail) else $error("watchdog failover wrong");

    property p_sticky;
        @(posedge clk) disable iff (!rst_sync_ff) clk_fail_ff |=> clk_fail_ff;
    endproperty
    a_sticky: assert property (p_sticky) else $error("failover released early");
endmodule
`default_nettype wire

// File: shared/clk_sel_pkg.sv
// Operation
// - Clock mechanism chosen from select pins during reset
// - PLL factors: 111x4 110x3 101x8 100x5 010x10 000x16
// - Code 011: PLL off only if disable set, amplifier bypassed, direct
// - Direct: half periods follow input duty cycle
// - Code 001: divide-by-two prescaler from oscillator
// - Prescaler: each phase lasts one input period
// - Non-PLL modes: PLL free-runs unless disable set
// - Both CPU clock edges trigger operations
// - Amplifier active except direct drive
// - Watchdog enabled after reset, disable bit stops it
// - Counter counts PLL clocks, cleared by input edges
// - Overflow: switch to PLL clock, flag, stay
package clk_sel_pkg;
    localparam logic [2:0] SEL_X4 = 3'h7;
    localparam logic [2:0] SEL_X3 = 3'h6;
    localparam logic [2:0] SEL_X8 = 3'h5;
    localparam logic [2:0] SEL_X5 = 3'h4;
    localparam logic [2:0] SEL_DIRECT = 3'h3;
    localparam logic [2:0] SEL_X10 = 3'h2;
    localparam logic [2:0] SEL_PRESC = 3'h1;
    localparam logic [2:0] SEL_X16 = 3'h0;
    localparam logic [2:0] SEL_RESET = SEL_X4;

    localparam logic [4:0] FACTOR_X1 = 5'h01;
    localparam logic [4:0] FACTOR_X3 = 5'h03;
    localparam logic [4:0] FACTOR_X4 = 5'h04;
    localparam logic [4:0] FACTOR_X5 = 5'h05;
    localparam logic [4:0] FACTOR_X8 = 5'h08;
    localparam logic [4:0] FACTOR_X10 = 5'h0A;
    localparam logic [4:0] FACTOR_X16 = 5'h10;
    // Zero factor stands for the divide-by-two prescaler
    localparam logic [4:0] FACTOR_DIV2 = 5'h00;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PLL_FREE_HALF_NS = 40;
    localparam int PLL_FREE_HALF_CYC = (PLL_FREE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OWD_OVERFLOW_CYC = 16;

    typedef enum logic [1:0] {
        SRC_PLL = 2'h0,
        SRC_PRESC = 2'h1,
        SRC_DIRECT = 2'h3,
        SRC_FAILSAFE = 2'h2
    } clk_src_t;

    typedef struct packed {
        logic pll_enable;
        logic osc_amp_enable;
        logic ext_clk_accept;
        logic [4:0] pll_factor;
    } clk_cfg_t;
endpackage

// File: rtl/osc_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module osc_watchdog #(
    parameter int OVERFLOW = clk_sel_pkg::OWD_OVERFLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events
    input wire logic enable,
    input wire logic pll_tick,
    input wire logic xtal_edge,
    // Failure pulse
    output logic overflow_ff
);
    logic [5:0] count_ff;
    logic [5:0] nxt_count;
    logic nxt_overflow;

    always_comb
    begin
        nxt_count = count_ff;
        nxt_overflow = 1'b0;
        // Input edge wins over a PLL tick in the same cycle
        if (!enable || xtal_edge)
        begin
            nxt_count = 6'h00;
        end
        else if (pll_tick)
        begin
            if (count_ff == 6'(OVERFLOW - 1))
            begin
                nxt_count = 6'h00;
                nxt_overflow = 1'b1;
            end
            else
            begin
                nxt_count = count_ff + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= 6'h00;
            overflow_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            overflow_ff <= nxt_overflow;
        end
    end

    property p_wd_clear;
        @(posedge clk) disable iff (!rst_n)
        (enable && xtal_edge) |=> (count_ff == 6'h00) && !overflow_ff;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared by edge");

    property p_wd_count;
        @(posedge clk) disable iff (!rst_n)
        (enable && pll_tick && !xtal_edge && count_ff < 6'(OVERFLOW - 1))
            |=> count_ff == $past(count_ff) + 6'h01;
    endproperty
    a_wd_count: assert property (p_wd_count) else $error("watchdog did not count");
endmodule
`default_nettype wire

// File: bench/xtal_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module xtal_source_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic run,
    input wire logic [3:0] hi_cyc,
    input wire logic [3:0] lo_cyc,
    // Input clock
    output logic crystal_input_pin
);
    logic level_ff = 1'b0;
    logic [3:0] cnt_ff = 4'h0;
    assign crystal_input_pin = level_ff;
    // A dead source freezes its level, as a failed crystal would
    always @(negedge clk)
    begin
        if (run && cnt_ff + 4'h1 >= (level_ff ? hi_cyc : lo_cyc))
        begin
            level_ff <= ~level_ff;
            cnt_ff <= 4'h0;
        end
        else if (run)
        begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

// File: bench/test_cpu_clock_mode_selector.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_clock_mode_selector;
    localparam int PLL_HALF = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] pins = 3'h7;
    logic owd_dis = 1'b0;
    logic run = 1'b1;
    logic [3:0] hi_cyc = 4'h3;
    logic [3:0] lo_cyc = 4'h5;
    logic xtal;
    logic cpu_clk;
    logic cpu_edge;
    logic owd_irq;
    logic clk_fail;
    clk_sel_pkg::clk_cfg_t cfg;
    int failures = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    xtal_source_model src_u (.clk(clk), .run(run), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
        .crystal_input_pin(xtal));
    cpu_clock_mode_selector #(.PLL_HALF(PLL_HALF), .OWD_OVERFLOW(16)) dut_u (
        .clk(clk), .rst_n(rst_n), .clock_select_pins(pins), .crystal_input_pin(xtal),
        .osc_watchdog_disable(owd_dis), .cpu_clk_ff(cpu_clk), .cpu_edge_ff(cpu_edge),
        .cfg_ff(cfg), .owd_irq_ff(owd_irq), .clk_fail_ff(clk_fail));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("failures %0d checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] cfg_exp(input logic [2:0] code, input logic dis);
        logic [4:0] f;
        case (code)
            3'h7: f = 5'h04;
            3'h6: f = 5'h03;
            3'h5: f = 5'h08;
            3'h4: f = 5'h05;
            3'h3: f = 5'h01;
            3'h2: f = 5'h0A;
            3'h1: f = 5'h00;
            default: f = 5'h10;
        endcase
        if (code == 3'h3)
            return {~dis, 2'b01, f};
        if (code == 3'h1)
            return {~dis, 2'b10, f};
        return {3'b110, f};
    endfunction
    // Straps flip four cycles after release so a late sample would show
    task automatic do_reset(input logic [2:0] code, input logic dis);
        @(negedge clk);
        rst_n = 1'b0;
        pins = code;
        owd_dis = dis;
        repeat (10) @(negedge clk);
        check({cpu_clk, cpu_edge, owd_irq, clk_fail, 4'h0}, 8'h00, "outs in reset");
        check(cfg, 8'h00, "cfg in reset");
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        pins = ~code;
    endtask
    task automatic phase_len(output int len);
        int n;
        n = 0;
        while (cpu_edge !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        len = 1;
        while (cpu_edge !== 1'b1 && len < 200)
        begin
            @(negedge clk);
            len++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_codes();
        for (int c = 0; c < 8; c++)
        begin
            do_reset(c[2:0], c[1]);
            check(cfg, cfg_exp(c[2:0], c[1]), "cfg");
            repeat (6) @(negedge clk);
            check(cfg, cfg_exp(c[2:0], c[1]), "cfg held");
        end
    endtask
    task automatic t_direct();
        int a;
        int b;
        logic c1;
        do_reset(3'h3, 1'b0);
        // Skip the cut phase where the clock leaves its reset level
        repeat (8) @(negedge clk);
        phase_len(a);
        phase_len(b);
        check(8'(a + b), 8'h08, "two half periods");
        check({7'h0, a == 3 || a == 5}, 8'h01, "half period");
        @(posedge clk);
        #1;
        c1 = cpu_clk;
        repeat (20)
        begin
            @(posedge clk);
            #1;
            // Registered copy of the level taken at this edge
            check({7'h0, cpu_clk}, {7'h0, xtal}, "direct follow");
            check({7'h0, cpu_edge}, {7'h0, cpu_clk ^ c1}, "edge pulse");
            c1 = cpu_clk;
        end
        check({7'h0, clk_fail}, 8'h00, "no fail");
    endtask
    task automatic t_presc();
        int a;
        hi_cyc = 4'h2;
        lo_cyc = 4'h3;
        do_reset(3'h1, 1'b1);
        repeat (3)
        begin
            phase_len(a);
            check(8'(a), 8'h05, "prescaler phase");
        end
        run = 1'b0;
        repeat (150)
        begin
            @(negedge clk);
            check({7'h0, owd_irq | clk_fail}, 8'h00, "disabled watchdog");
        end
        run = 1'b1;
    endtask
    task automatic t_failover();
        int n;
        int a;
        hi_cyc = 4'h3;
        lo_cyc = 4'h5;
        do_reset(3'h3, 1'b0);
        repeat (20) @(negedge clk);
        // Stop right after a known input edge so the overflow time is fixed
        @(xtal);
        run = 1'b0;
        n = 0;
        while (owd_irq !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        // Tick phase against the last input edge gives a one-tick spread
        a = clk_sel_pkg::OWD_OVERFLOW_CYC * 2 * PLL_HALF;
        check({7'h0, n >= a - 1 && n <= a + 2}, 8'h01, "overflow time");
        check({6'h0, clk_fail, cfg.pll_enable}, 8'h03, "failover");
        @(negedge clk);
        check({7'h0, owd_irq}, 8'h00, "irq pulse");
        // First phase may be cut where the source switches over
        phase_len(a);
        phase_len(a);
        check(8'(a), 8'(PLL_HALF), "pll phase");
        run = 1'b1;
        repeat (30) @(negedge clk);
        check({7'h0, clk_fail}, 8'h01, "sticky");
        do_reset(3'h3, 1'b0);
        check({7'h0, clk_fail}, 8'h00, "fail cleared");
    endtask
    task automatic t_pll();
        int a;
        do_reset(3'h0, 1'b0);
        phase_len(a);
        check(8'(a), 8'(PLL_HALF), "pll mode phase");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        t_codes();
        t_direct();
        t_presc();
        t_failover();
        t_pll();
        complete_run();
    end
    // Whole run needs some 600 cycles
    initial
    begin
        #200000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
